// File: logic/rted_axis_cmp.sv
// One axis comparator: magnitude of a sample against the threshold.
`timescale 1ns/1ns
`default_nettype none
module rted_axis_cmp (
  // Sample and threshold
  input  wire logic [rted_pkg::SAMPLE_W-1:0] sample_i,
  input  wire logic [rted_pkg::THRESH_W-1:0] thresh_i,
  // Comparator outputs
  output logic                               above_o,
  output logic                               below_o
);
  logic [rted_pkg::SAMPLE_W-1:0] mag;

  always_comb begin
    if (sample_i[rted_pkg::SAMPLE_W-1]) begin
      mag = (~sample_i) + 16'h0001;
    end else begin
      mag = sample_i;
    end
  end

  assign above_o = mag > {1'b0, thresh_i};
  assign below_o = mag < {1'b0, thresh_i};
endmodule
`default_nettype wire

// File: logic/rted_core.sv
// Rate threshold event detector: registers, qualification and pin drive.
`timescale 1ns/1ns
`default_nettype none
module rted_core (
  // Clock, reset, enable
  input  wire logic                        sys_clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        clk_en_i,
  // Sample stream, one strobe per output sample set
  input  wire logic                        sample_stb_i,
  input  wire rted_pkg::rted_sample_t      raw_sample_i,
  input  wire rted_pkg::rted_sample_t      hp_sample_i,
  // Control bits held outside this block
  input  wire logic                        pin_one_event_en_i,
  input  wire logic                        pin_polarity_i,
  input  wire logic [1:0]                  event_path_sel_i,
  input  wire logic [1:0]                  highpass_mode_field_i,
  input  wire logic                        ref_read_i,
  // Register port
  input  wire logic                        cfg_wr_i,
  input  wire logic                        dur_wr_i,
  input  wire logic [5:0]                  thr_wr_i,
  input  wire logic [7:0]                  wdata_i,
  input  wire logic                        src_rd_i,
  // Readback
  output logic [7:0]                       event_config_reg_o,
  output logic [7:0]                       event_min_duration_o,
  output logic [47:0]                      threshold_o,
  output logic [7:0]                       event_source_reg_o,
  // Event outputs
  output logic                             event_irq_pin_o,
  output logic                             hp_reset_o
);
  logic [7:0]               cfg, next_cfg;
  logic [7:0]               dur, next_dur;
  rted_pkg::rted_thr_t      thr [3];
  rted_pkg::rted_thr_t      next_thr [3];
  logic [7:0]               src, next_src;
  logic [6:0]               cnt, next_cnt;
  rted_pkg::rted_state_t    state, next_state;
  logic                     event_q, next_event;
  logic                     irq, next_irq;
  logic                     hprst, next_hprst;
  logic                     stb_pend, next_stb_pend;
  logic [5:0]               cmp;
  logic [5:0]               en_bits;
  logic                     any_on;
  logic                     all_on;
  logic                     cond;
  logic                     evt_raw;
  rted_pkg::rted_sample_t   smp;

  // Combine enabled comparator bits into one condition.
  function automatic logic combine(input logic [5:0] c,
                                   input logic [5:0] e,
                                   input logic       and_mode);
    logic r;
    r = 1'b0;
    if (and_mode) begin
      r = (e != 6'h00) && ((c & e) == e);
    end else begin
      r = (c & e) != 6'h00;
    end
    return r;
  endfunction

  assign smp = (event_path_sel_i == rted_pkg::PATH_HIGHPASS) ?
               hp_sample_i : raw_sample_i;

  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      // threshold from upper bits 14..8 and lower byte
      rted_axis_cmp u_cmp (
        .sample_i (smp[a*rted_pkg::SAMPLE_W +: rted_pkg::SAMPLE_W]),
        .thresh_i ({thr[a].upper[6:0], thr[a].lower}),
        .above_o  (cmp[2*a+1]),
        .below_o  (cmp[2*a])
      );
    end
  endgenerate

  assign en_bits = cfg[5:0];
  assign any_on  = combine(cmp, en_bits, 1'b0);
  assign all_on  = combine(cmp, en_bits, 1'b1);
  // mode bit selects AND or OR
  assign cond    = cfg[rted_pkg::CFG_COMBINE] ? all_on : any_on;

  // Register writes.
  always_comb begin
    next_cfg = cfg;
    next_dur = dur;
    for (int i = 0; i < 3; i++) begin
      next_thr[i] = thr[i];
      if (thr_wr_i[2*i+1]) begin
        next_thr[i].upper = {1'b0, wdata_i[6:0]};
      end
      if (thr_wr_i[2*i]) begin
        next_thr[i].lower = wdata_i;
      end
    end
    if (cfg_wr_i) begin
      next_cfg = wdata_i;
    end
    if (dur_wr_i) begin
      next_dur = wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cfg <= rted_pkg::CFG_RESET;
      dur <= rted_pkg::DUR_RESET;
      for (int i = 0; i < 3; i++) begin
        thr[i] <= {rted_pkg::THR_RESET, rted_pkg::THR_RESET};
      end
    end else if (clk_en_i) begin
      cfg <= next_cfg;
      dur <= next_dur;
      for (int i = 0; i < 3; i++) begin
        thr[i] <= next_thr[i];
      end
    end
  end

  // Qualification state machine, stepped only on sample strobes.
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_event    = event_q;
    next_stb_pend = 1'b0;
    evt_raw       = 1'b0;
    if (sample_stb_i) begin
      case (state)
        rted_pkg::RTED_IDLE: begin
          // restart on early drop; zero fires at once
          if (!cond) begin
            next_cnt = 7'h00;
          end else if (cnt >= dur[6:0]) begin
            next_state = rted_pkg::RTED_ON;
            next_event = 1'b1;
            next_cnt   = 7'h00;
            evt_raw    = 1'b1;
          end else begin
            next_cnt = cnt + 7'h01;
          end
        end
        rted_pkg::RTED_ON: begin
          if (!cond) begin
            // hold for duration samples with wait
            if (dur[rted_pkg::DUR_WAIT] && dur[6:0] != 7'h00) begin
              next_state = rted_pkg::RTED_HOLD;
              next_cnt   = 7'h01;
            end else begin
              next_state = rted_pkg::RTED_IDLE;
              next_event = 1'b0;
            end
          end
        end
        rted_pkg::RTED_HOLD: begin
          if (cond) begin
            next_state = rted_pkg::RTED_ON;
            next_cnt   = 7'h00;
          end else if (cnt >= dur[6:0]) begin
            next_state = rted_pkg::RTED_IDLE;
            next_event = 1'b0;
            next_cnt   = 7'h00;
          end else begin
            next_cnt = cnt + 7'h01;
          end
        end
        default: begin
          next_state = rted_pkg::RTED_IDLE;
          next_cnt   = 7'h00;
          next_event = 1'b0;
        end
      endcase
    end
    next_stb_pend = evt_raw;
  end

  // one count per output sample period
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state    <= rted_pkg::RTED_IDLE;
      cnt      <= 7'h00;
      event_q  <= 1'b0;
      stb_pend <= 1'b0;
    end else if (clk_en_i) begin
      state    <= next_state;
      cnt      <= next_cnt;
      event_q  <= next_event;
      stb_pend <= next_stb_pend;
    end
  end

  // Source register, pin and filter reset.
  always_comb begin
    next_src   = src;
    next_irq   = irq;
    next_hprst = 1'b0;
    if (src_rd_i) begin
      next_src[rted_pkg::SRC_ACTIVE] = 1'b0;
    end
    // record cause; set wins over read
    if (cfg[rted_pkg::CFG_LATCH]) begin
      if (next_event && !src[rted_pkg::SRC_ACTIVE]) begin
        next_src = {1'b0, 1'b1, cmp & en_bits};
      end else if (next_event && src_rd_i) begin
        next_src = {1'b0, 1'b1, cmp & en_bits};
      end
    end else begin
      next_src = {1'b0, next_event, cmp & en_bits};
      if (src_rd_i && !next_event) begin
        next_src[rted_pkg::SRC_ACTIVE] = 1'b0;
      end
    end
    next_irq = (pin_one_event_en_i & next_src[rted_pkg::SRC_ACTIVE]) ^
               pin_polarity_i;
    next_hprst = ref_read_i ||
                 (stb_pend && highpass_mode_field_i == rted_pkg::HP_AUTORESET);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      src   <= 8'h00;
      irq   <= 1'b0;
      hprst <= 1'b0;
    end else if (clk_en_i) begin
      src   <= next_src;
      irq   <= next_irq;
      hprst <= next_hprst;
    end
  end

  assign event_config_reg_o   = cfg;
  assign event_min_duration_o = dur;
  assign threshold_o          = {thr[2], thr[1], thr[0]};
  assign event_source_reg_o   = src;
  assign event_irq_pin_o      = irq;
  assign hp_reset_o           = hprst;

  reset_values_a: assert property (
    @(posedge sys_clk_i) $fell(sys_rst_i) |->
      !dur[rted_pkg::DUR_WAIT] && !cfg[rted_pkg::CFG_COMBINE])
    else $error("Config not cleared by reset.");
  or_mode_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && sample_stb_i && state == rted_pkg::RTED_IDLE &&
      dur[6:0] == 7'h00 && !cfg[rted_pkg::CFG_COMBINE] &&
      ((cmp & en_bits) != 6'h00) |=> event_q)
    else $error("OR combination missed an event.");
  and_mode_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && sample_stb_i && state == rted_pkg::RTED_IDLE &&
      cfg[rted_pkg::CFG_COMBINE] && ((cmp & en_bits) != en_bits) |=>
      !event_q)
    else $error("AND combination fired early.");
  no_wait_drop_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && sample_stb_i && state == rted_pkg::RTED_ON && !cond &&
      !dur[rted_pkg::DUR_WAIT] |=> !event_q)
    else $error("Event held without release wait.");
  wait_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && sample_stb_i && state == rted_pkg::RTED_ON && !cond &&
      dur[rted_pkg::DUR_WAIT] && dur[6:0] > 7'h01 |=> event_q)
    else $error("Release wait not honoured.");
  no_step_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !sample_stb_i || !clk_en_i |=> $stable(cnt) && $stable(state))
    else $error("Counter moved without a sample.");
  pin_gate_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && !pin_one_event_en_i |=> irq == $past(pin_polarity_i))
    else $error("Pin active while disabled.");
  latch_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && cfg[rted_pkg::CFG_LATCH] && src[rted_pkg::SRC_ACTIVE] &&
      !src_rd_i && !cfg_wr_i |=> src[rted_pkg::SRC_ACTIVE])
    else $error("Latched flag dropped without read.");
  ref_reset_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && ref_read_i |=> hprst)
    else $error("Reference read did not reset filter.");
  cover_event_c: cover property (@(posedge sys_clk_i) $rose(event_q));
  cover_hold_c: cover property (@(posedge sys_clk_i)
    state == rted_pkg::RTED_HOLD);
  cover_read_c: cover property (@(posedge sys_clk_i)
    src_rd_i && src[rted_pkg::SRC_ACTIVE]);
  cover_auto_c: cover property (@(posedge sys_clk_i) hprst && !ref_read_i);
endmodule
`default_nettype wire

// File: logic/rted_pkg.sv
// Constants and carrier types of the rate threshold event detector.
// Functional notes
// - Combine bit 0: event when any enabled comparator output is true.
// - Combine bit 1: event only when all enabled comparator outputs are true.
// - Combine bit selects AND at 1, OR at 0; resets to 0.
// - Condition met raises event and records causing axis directions in source register.
// - Reading source register clears active flag, drops pin, lets latched contents refresh.
// - Threshold is upper byte bits 14..8 (bit 7 unused) plus lower byte 7..0.
// - One threshold step is about 7.5 millidegrees per second.
// - Threshold is unsigned magnitude; comparison uses absolute sample value.
// - Axis above condition: magnitude greater than threshold.
// - Axis below condition: magnitude less than threshold.
// - Six enables gate which axis/direction comparator outputs take part.
// - Latch bit 0 (reset): event follows the condition.
// - Latch bit 1: event holds until source register is read.
// - Seven-bit duration, reset zero, sets consecutive samples needed before event.
// - Duration counts output sample periods: N counts equal N over sample rate.
// - Duration register top bit is release-wait enable, reset 0.
// - Release-wait off: event drops as soon as condition ends.
// - Release-wait on: event holds for duration further samples after condition ends.
// - Reading reference register resets high-pass filter to current rate at once.
// - Event reaches interrupt pin only when pin-one enable bit is set.
// - Pin polarity bit: 0 active high, 1 active low.
// - Path select 01 makes comparators use high-pass filtered data.
// - High-pass mode 11 resets the filter whenever the event occurs.
package rted_pkg;
  localparam int          SAMPLE_W       = 16;
  localparam int          THRESH_W       = 15;
  localparam int          DUR_W          = 7;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [7:0]  DUR_RESET      = 8'h00;
  localparam logic [7:0]  THR_RESET      = 8'h00;
  localparam int          CFG_COMBINE    = 7;
  localparam int          CFG_LATCH      = 6;
  localparam int          DUR_WAIT       = 7;
  localparam int          SRC_ACTIVE     = 6;
  localparam logic [1:0]  PATH_HIGHPASS  = 2'h1;
  localparam logic [1:0]  HP_AUTORESET   = 2'h3;
  // one count scale
  // Only a scale for software; the comparators work in raw counts.
  localparam int          THR_LSB_UDPS   = 7500;

  typedef struct packed {
    logic [SAMPLE_W-1:0] z;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] x;
  } rted_sample_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } rted_thr_t;

  typedef enum logic [2:0] {
    RTED_IDLE  = 3'b001,
    RTED_ON    = 3'b010,
    RTED_HOLD  = 3'b100
  } rted_state_t;
endpackage

// File: testbench/rted_core_test.sv
// Self-checking bench of the rate threshold event detector.
`timescale 1ns/1ns
`default_nettype none
module rted_core_test;
  logic                   sys_clk_i, sys_rst_i, clk_en, stb, pen, pol;
  logic                   cfg_wr, dur_wr, src_rd, ref_rd, pin, hpr, ev, lat;
  logic [1:0]             path, hp_mode;
  logic [5:0]             thr_wr;
  logic [7:0]             wdata, cfg_q, dur_q, src_q, cfg, dur;
  logic [47:0]            thr_q;
  logic [31:0]            lfsr;
  rted_pkg::rted_sample_t raw, hp;
  int                     th[3];
  int                     run, hold, h, mismatches, n_tests;

  always #5 sys_clk_i = ~sys_clk_i;

  rted_core u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en), .sample_stb_i(stb), .raw_sample_i(raw),
    .hp_sample_i(hp), .pin_one_event_en_i(pen), .pin_polarity_i(pol),
    .event_path_sel_i(path), .highpass_mode_field_i(hp_mode),
    .ref_read_i(ref_rd), .cfg_wr_i(cfg_wr), .dur_wr_i(dur_wr),
    .thr_wr_i(thr_wr), .wdata_i(wdata), .src_rd_i(src_rd),
    .event_config_reg_o(cfg_q), .event_min_duration_o(dur_q),
    .threshold_o(thr_q), .event_source_reg_o(src_q),
    .event_irq_pin_o(pin), .hp_reset_o(hpr));

  rted_host u_host (.sys_clk_i(sys_clk_i), .cfg_wr_o(cfg_wr),
    .dur_wr_o(dur_wr), .thr_wr_o(thr_wr), .wdata_o(wdata),
    .src_rd_o(src_rd), .ref_read_o(ref_rd));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Shrinks a random rate so that it often lands near the threshold.
  function automatic logic [15:0] sx(input logic [15:0] v);
    return {{3{v[15]}}, v[15:3]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [5:0] cmp(input rted_pkg::rted_sample_t s);
    logic [15:0] a;
    logic [5:0]  r;
    int          m;
    for (int i = 0; i < 3; i++) begin
      a = s[16*i +: 16];
      m = a[15] ? 65536 - int'(a) : int'(a);
      r[2*i+1] = m > th[i];
      r[2*i] = m < th[i];
    end
    return r;
  endfunction

  task automatic model(input logic [5:0] c);
    logic [5:0] m;
    logic       cnd;
    m = cfg[5:0];
    cnd = cfg[7] ? (m != 0 && (c & m) == m) : |(c & m);
    // A condition that returns during the wait keeps the event alive.
    if (cnd) begin
      run = ev ? run : run + 1;
      hold = 0;
      if (run > int'(dur[6:0]))
        ev = 1'b1;
    end else if (ev && dur[7] && hold < int'(dur[6:0])) begin
      run = 0;
      hold++;
    end else begin
      run = 0;
      hold = 0;
      ev = 1'b0;
    end
    lat = lat | ev;
  endtask

  function automatic logic live();
    return cfg[6] ? lat : ev;
  endfunction

  task automatic smp(input rted_pkg::rted_sample_t r,
                     input rted_pkg::rted_sample_t s);
    @(negedge sys_clk_i);
    raw = r;
    hp = s;
    stb = 1'b1;
    @(negedge sys_clk_i);
    stb = 1'b0;
    model(cmp(path == 2'h1 ? s : r));
    @(negedge sys_clk_i);
    chk("pin", {7'h0, pin}, {7'h0, pen ? live() ^ pol : pol});
    chk("active", {7'h0, src_q[6]}, {7'h0, live()});
  endtask

  task automatic rst;
    @(negedge sys_clk_i);
    sys_rst_i = 1'b1;
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    {cfg, dur, ev, lat} = '0;
    run = 0;
    hold = 0;
    th = '{0, 0, 0};
  endtask

  task automatic setup(input logic [7:0] c, input logic [7:0] d, input int t);
    cfg = c;
    dur = d;
    u_host.access(0, c);
    u_host.access(1, d);
    for (int a = 0; a < 3; a++) begin
      th[a] = t + a * 300;
      u_host.access(2 * a + 3, 8'(th[a] >> 8));
      u_host.access(2 * a + 2, 8'(th[a]));
    end
  endtask

  task automatic pat(input logic [7:0] bits, input logic [15:0] lo);
    for (int i = 7; i >= 0; i--)
      smp(bits[i] ? {3{16'd500}} : {32'h0, lo}, '0);
  endtask

  task automatic cnt(output int n);
    n = 0;
    repeat (6) begin
      @(posedge sys_clk_i);
      #1;
      if (hpr === 1'b1)
        n++;
    end
  endtask

  initial begin
    {sys_clk_i, stb, pol, path, hp_mode, raw, hp} = '0;
    {sys_rst_i, clk_en, pen} = 3'b111;
    {mismatches, n_tests, lfsr} = {32'h0, 32'h0, 32'h27e8};
    repeat (10) @(negedge sys_clk_i);
    rst;
    chk("cfg", cfg_q, rted_pkg::CFG_RESET);
    chk("dur", dur_q, rted_pkg::DUR_RESET);
    u_host.access(3, 8'hff);
    @(negedge sys_clk_i);
    chk("thr_up", thr_q[15:8], 8'h7f);
    $display("register test done");
    for (int k = 0; k < 400; k++) begin
      lfsr = nxt(lfsr);
      if (k % 40 == 0) begin
        rst;
        path = {1'b0, lfsr[10]};
        pol = lfsr[11];
        pen = lfsr[12] | lfsr[11];
        setup({lfsr[7], 1'b0, lfsr[5:0]}, {6'h0, lfsr[9:8]},
              int'(lfsr[31:20]));
      end
      smp({sx(lfsr[31:16]), sx(lfsr[15:0]), sx(lfsr[23:8])},
          {sx(lfsr[27:12]), sx(lfsr[19:4]), sx({lfsr[11:0], lfsr[31:28]})});
    end
    $display("random test done");
    {path, pol, pen} = 4'b0001;
    rst;
    setup(8'h02, 8'h03, 100);
    pat(8'b11101111, 16'h0);
    rst;
    setup(8'h02, 8'h82, 100);
    pat(8'b11100011, 16'h0);
    $display("duration test done");
    rst;
    setup(8'h02, 8'h00, 100);
    fork u_host.access(9, 8'h0); cnt(h); join
    chk("ref_reset", 8'(h), 8'h01);
    fork smp({3{16'd500}}, '0); cnt(h); join
    chk("no_auto", 8'(h), 8'h00);
    smp('0, '0);
    hp_mode = 2'h3;
    fork smp({3{16'd500}}, '0); cnt(h); join
    chk("auto_reset", 8'(h), 8'h01);
    hp_mode = 2'h0;
    $display("filter reset test done");
    rst;
    setup(8'hca, 8'h00, 100);
    pat(8'b01000000, 16'hfe0c);
    chk("src", src_q, 8'h4a);
    u_host.access(8, 8'h0);
    lat = 1'b0;
    @(negedge sys_clk_i);
    chk("pin_read", {7'h0, pin}, 8'h00);
    chk("src_read", {7'h0, src_q[6]}, 8'h00);
    clk_en = 1'b0;
    raw = {3{16'd500}};
    stb = 1'b1;
    @(negedge sys_clk_i);
    stb = 1'b0;
    clk_en = 1'b1;
    @(negedge sys_clk_i);
    chk("frozen", {7'h0, pin}, 8'h00);
    $display("latch test done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// File: testbench/rted_host.sv
// Host-side model that works the register port of the detector.
`timescale 1ns/1ns
`default_nettype none
module rted_host (
  // Clock
  input  wire logic       sys_clk_i,
  // Register port
  output logic            cfg_wr_o,
  output logic            dur_wr_o,
  output logic [5:0]      thr_wr_o,
  output logic [7:0]      wdata_o,
  output logic            src_rd_o,
  output logic            ref_read_o
);
  initial begin
    {cfg_wr_o, dur_wr_o, thr_wr_o, wdata_o, src_rd_o, ref_read_o} = '0;
  end

  // One access a call: 0 config, 1 duration, 2..7 thresholds, 8 source, 9 ref.
  task automatic access(input int sel, input logic [7:0] d);
    @(negedge sys_clk_i);
    cfg_wr_o = (sel == 0);
    dur_wr_o = (sel == 1);
    thr_wr_o = (sel > 1 && sel < 8) ? 6'(1 << (sel - 2)) : 6'h00;
    src_rd_o = (sel == 8);
    ref_read_o = (sel == 9);
    wdata_o = d;
    @(negedge sys_clk_i);
    {cfg_wr_o, dur_wr_o, thr_wr_o, wdata_o, src_rd_o, ref_read_o} = '0;
  endtask
endmodule
`default_nettype wire
